// ==== src/cdsws_sequencer.sv ====
// low-power card sense cycle with wake outputs for the transmitter supply regulator
`timescale 1ns/1ps
`default_nettype none
module cdsws_sequencer #(
    parameter logic [15:0] STANDBY_US = 16'd100
) (
    // clock and reset
    input wire logic clock,
    input wire logic reset_n,
    // register port
    input wire logic [7:0] addr,
    input wire logic [31:0] wr_data,
    input wire logic wr_en,
    input wire logic rd_en,
    output logic [31:0] rd_data,
    // gain measurement, same clock
    input wire logic [9:0] gain_value,
    // pins
    input wire logic host_select_n,
    input wire logic rf_level_detect,
    // regulator wake, field and gain gear
    output logic wake_output_one,
    output logic wake_output_two,
    output logic rf_field_on,
    output logic [3:0] gain_gear,
    // interrupt
    output logic card_found_interrupt
);
    cdsws_timer_if tmr ();

    cdsws_delay_timer u_timer (
        .clock(clock),
        .reset_n(reset_n),
        .tmr(tmr)
    );

    cdsws_pkg::cdsws_state_e state_q;
    logic [cdsws_pkg::REF_W-1:0] reference_q;
    logic [cdsws_pkg::REF_W-1:0] gain_cfg_q;
    logic [7:0] field_q;
    logic [7:0] threshold_q;
    logic [cdsws_pkg::CTL_W-1:0] ctl_q;
    logic [7:0] lead_q;
    logic [7:0] lag_q;
    logic [cdsws_pkg::IRQ_W-1:0] irq_mask_q;
    logic [cdsws_pkg::IRQ_W-1:0] irq_status_q;
    logic irq_q;
    logic [31:0] rd_data_q;
    logic tmr_start_q;
    logic [15:0] tmr_us_q;
    logic wake1_q;
    logic wake2_q;
    logic rf_q;
    logic single_q;
    logic [9:0] meas_q;
    logic [9:0] meas_ref_q;
    logic meas_ref_valid_q;
    logic single_found_q;
    logic single_done_q;
    logic [3:0] gear_q;
    logic ev_found_q;
    logic ev_abort_q;
    logic ev_single_q;
    logic [1:0] sync1_q;
    logic [1:0] sync2_q;
    logic [1:0] sync3_q;
    logic [1:0] pin_q;

    logic [1:0] sel;
    logic wake1_en;
    logic start_loop;
    logic start_single;
    logic stop_req;
    logic tmr_done;
    logic [15:0] lead_us;
    logic [15:0] lag_us;
    logic [15:0] field_us;
    logic [9:0] ref_gain;
    logic ref_ok;
    logic [9:0] diff;
    logic hit;

    assign sel = ctl_q[cdsws_pkg::CTL_SEL_MSB:0];
    assign wake1_en = ctl_q[cdsws_pkg::CTL_WAKE1_FIELD] | ctl_q[cdsws_pkg::CTL_WAKE1_STANDBY];
    assign start_loop = wr_en && addr == cdsws_pkg::ADDR_SENSE_COMMAND
        && wr_data[cdsws_pkg::CMD_START];
    assign start_single = wr_en && addr == cdsws_pkg::ADDR_SINGLE_DETECT;
    // host select and outside field end the loop just like a software stop
    assign stop_req = (wr_en && addr == cdsws_pkg::ADDR_SENSE_COMMAND
        && wr_data[cdsws_pkg::CMD_STOP]) | pin_q[1] | pin_q[0];
    // a done that overlaps a fresh start belongs to the cancelled run
    assign tmr_done = tmr.done && !tmr_start_q;
    assign tmr.start = tmr_start_q;
    assign tmr.us = tmr_us_q;
    assign lead_us = 16'(lead_q) * 16'(cdsws_pkg::LEAD_UNIT_US);
    assign lag_us = 16'(lag_q) * 16'(cdsws_pkg::LAG_UNIT_US);
    assign field_us = 16'(field_q) * 16'(cdsws_pkg::FIELD_UNIT_US);

    // reference source; the reserved code never reports a card
    always_comb
    begin
        ref_gain = reference_q[cdsws_pkg::GAIN_W-1:0];
        ref_ok = 1'b1;
        unique case (sel)
            cdsws_pkg::REF_STORED: ref_gain = reference_q[cdsws_pkg::GAIN_W-1:0];
            cdsws_pkg::REF_MEASURE:
            begin
                ref_gain = meas_ref_q;
                ref_ok = meas_ref_valid_q;
            end
            cdsws_pkg::REF_GAIN_CFG: ref_gain = gain_cfg_q[cdsws_pkg::GAIN_W-1:0];
            cdsws_pkg::REF_RESERVED: ref_ok = 1'b0;
        endcase
    end

    assign diff = (ref_gain > meas_q) ? ref_gain - meas_q : meas_q - ref_gain;
    assign hit = ref_ok && diff > {2'h0, threshold_q};

    // pins pass three flops; a change counts once the last two agree
    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
        begin
            sync1_q <= 2'h0;
            sync2_q <= 2'h0;
            sync3_q <= 2'h0;
            pin_q <= 2'h0;
        end
        else
        begin
            sync1_q <= {~host_select_n, rf_level_detect};
            sync2_q <= sync1_q;
            sync3_q <= sync2_q;
            pin_q <= (sync2_q & sync3_q) | (pin_q & (sync2_q | sync3_q));
        end
    end

    // card sense sequence
    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
        begin
            state_q <= cdsws_pkg::ST_IDLE;
            tmr_start_q <= 1'b0;
            tmr_us_q <= 16'h0000;
            wake1_q <= 1'b0;
            rf_q <= 1'b0;
            single_q <= 1'b0;
            meas_q <= 10'h000;
            ev_found_q <= 1'b0;
            ev_abort_q <= 1'b0;
            ev_single_q <= 1'b0;
        end
        else
        begin
            tmr_start_q <= 1'b0;
            ev_found_q <= 1'b0;
            ev_abort_q <= 1'b0;
            ev_single_q <= 1'b0;
            if (state_q != cdsws_pkg::ST_IDLE && stop_req)
            begin
                state_q <= cdsws_pkg::ST_IDLE;
                rf_q <= 1'b0;
                wake1_q <= 1'b0;
                ev_abort_q <= 1'b1;
            end
            else
            begin
                unique case (state_q)
                    cdsws_pkg::ST_IDLE:
                        if (start_single && !stop_req)
                        begin
                            single_q <= 1'b1;
                            state_q <= wake1_en ? cdsws_pkg::ST_LEAD : cdsws_pkg::ST_FIELD;
                            wake1_q <= wake1_en;
                            rf_q <= !wake1_en;
                            tmr_us_q <= wake1_en ? lead_us : field_us;
                            tmr_start_q <= 1'b1;
                        end
                        else if (start_loop && !stop_req)
                        begin
                            single_q <= 1'b0;
                            state_q <= cdsws_pkg::ST_STANDBY;
                            tmr_us_q <= STANDBY_US;
                            tmr_start_q <= 1'b1;
                        end
                    cdsws_pkg::ST_STANDBY:
                        if (tmr_done)
                        begin
                            state_q <= wake1_en ? cdsws_pkg::ST_LEAD : cdsws_pkg::ST_FIELD;
                            wake1_q <= wake1_en;
                            rf_q <= !wake1_en;
                            tmr_us_q <= wake1_en ? lead_us : field_us;
                            tmr_start_q <= 1'b1;
                        end
                    cdsws_pkg::ST_LEAD:
                        if (tmr_done)
                        begin
                            state_q <= cdsws_pkg::ST_FIELD;
                            rf_q <= 1'b1;
                            tmr_us_q <= field_us;
                            tmr_start_q <= 1'b1;
                        end
                    cdsws_pkg::ST_FIELD:
                        if (tmr_done)
                        begin
                            rf_q <= 1'b0;
                            meas_q <= gain_value;
                            state_q <= wake1_q ? cdsws_pkg::ST_LAG : cdsws_pkg::ST_DECIDE;
                            tmr_us_q <= lag_us;
                            tmr_start_q <= wake1_q;
                        end
                    cdsws_pkg::ST_LAG:
                        if (tmr_done)
                        begin
                            wake1_q <= 1'b0;
                            state_q <= cdsws_pkg::ST_DECIDE;
                        end
                    cdsws_pkg::ST_DECIDE:
                    begin
                        wake1_q <= 1'b0;
                        ev_found_q <= hit;
                        ev_single_q <= single_q;
                        if (hit || single_q)
                        begin
                            state_q <= cdsws_pkg::ST_IDLE;
                        end
                        else
                        begin
                            state_q <= cdsws_pkg::ST_STANDBY;
                            tmr_us_q <= STANDBY_US;
                            tmr_start_q <= 1'b1;
                        end
                    end
                    default: state_q <= cdsws_pkg::ST_IDLE;
                endcase
            end
        end
    end

    // measured reference, taken once per start, and detection results
    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
        begin
            meas_ref_q <= 10'h000;
            meas_ref_valid_q <= 1'b0;
            wake2_q <= 1'b0;
            single_found_q <= 1'b0;
            single_done_q <= 1'b0;
            gear_q <= 4'h0;
        end
        else
        begin
            gear_q <= (sel == cdsws_pkg::REF_GAIN_CFG)
                ? gain_cfg_q[cdsws_pkg::GEAR_MSB:cdsws_pkg::GEAR_LSB]
                : reference_q[cdsws_pkg::GEAR_MSB:cdsws_pkg::GEAR_LSB];
            if (state_q == cdsws_pkg::ST_IDLE && (start_loop || start_single) && !stop_req)
            begin
                meas_ref_valid_q <= 1'b0;
                wake2_q <= 1'b0;
                single_found_q <= 1'b0;
                single_done_q <= 1'b0;
            end
            else if (state_q == cdsws_pkg::ST_DECIDE && !stop_req)
            begin
                if (sel == cdsws_pkg::REF_MEASURE && !meas_ref_valid_q)
                begin
                    meas_ref_q <= meas_q;
                    meas_ref_valid_q <= 1'b1;
                end
                if (hit && ctl_q[cdsws_pkg::CTL_WAKE2_DETECT])
                begin
                    wake2_q <= 1'b1;
                end
                if (single_q)
                begin
                    single_found_q <= hit;
                    single_done_q <= 1'b1;
                end
            end
        end
    end

    // configuration writes
    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
        begin
            reference_q <= cdsws_pkg::REF_RESET;
            gain_cfg_q <= cdsws_pkg::REF_RESET;
            field_q <= cdsws_pkg::BYTE_RESET;
            threshold_q <= cdsws_pkg::BYTE_RESET;
            ctl_q <= cdsws_pkg::CTL_RESET;
            lead_q <= cdsws_pkg::BYTE_RESET;
            lag_q <= cdsws_pkg::BYTE_RESET;
            irq_mask_q <= cdsws_pkg::IRQ_RESET;
        end
        else if (wr_en)
        begin
            unique case (addr)
                cdsws_pkg::ADDR_DETECT_REFERENCE: reference_q <= wr_data[cdsws_pkg::REF_W-1:0];
                cdsws_pkg::ADDR_GAIN_CONTROL: gain_cfg_q <= wr_data[cdsws_pkg::REF_W-1:0];
                cdsws_pkg::ADDR_FIELD_ON_DURATION: field_q <= wr_data[7:0];
                cdsws_pkg::ADDR_DETECT_THRESHOLD: threshold_q <= wr_data[7:0];
                cdsws_pkg::ADDR_REF_OUT_CONTROL: ctl_q <= wr_data[cdsws_pkg::CTL_W-1:0];
                cdsws_pkg::ADDR_OUTPUT_LEAD: lead_q <= wr_data[7:0];
                cdsws_pkg::ADDR_OUTPUT_LAG: lag_q <= wr_data[7:0];
                cdsws_pkg::ADDR_IRQ_MASK: irq_mask_q <= wr_data[cdsws_pkg::IRQ_W-1:0];
                default: ;
            endcase
        end
    end

    // sticky events; a read clears, an event in the same cycle survives
    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
        begin
            irq_status_q <= cdsws_pkg::IRQ_RESET;
            irq_q <= 1'b0;
        end
        else
        begin
            irq_status_q <= ((rd_en && addr == cdsws_pkg::ADDR_IRQ_STATUS)
                ? cdsws_pkg::IRQ_RESET : irq_status_q) | {ev_single_q, ev_abort_q, ev_found_q};
            irq_q <= |(irq_status_q & irq_mask_q);
        end
    end

    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
        begin
            rd_data_q <= 32'h0000_0000;
        end
        else if (rd_en)
        begin
            unique case (addr)
                cdsws_pkg::ADDR_SINGLE_DETECT: rd_data_q <= {6'h00, meas_q, 14'h0000,
                    single_done_q, single_found_q};
                cdsws_pkg::ADDR_DETECT_REFERENCE: rd_data_q <= 32'(reference_q);
                cdsws_pkg::ADDR_GAIN_CONTROL: rd_data_q <= 32'(gain_cfg_q);
                cdsws_pkg::ADDR_FIELD_ON_DURATION: rd_data_q <= 32'(field_q);
                cdsws_pkg::ADDR_DETECT_THRESHOLD: rd_data_q <= 32'(threshold_q);
                cdsws_pkg::ADDR_REF_OUT_CONTROL: rd_data_q <= 32'(ctl_q);
                cdsws_pkg::ADDR_OUTPUT_LEAD: rd_data_q <= 32'(lead_q);
                cdsws_pkg::ADDR_OUTPUT_LAG: rd_data_q <= 32'(lag_q);
                cdsws_pkg::ADDR_SENSE_STATUS: rd_data_q <= 32'({wake2_q, wake1_q, rf_q, state_q});
                cdsws_pkg::ADDR_IRQ_STATUS: rd_data_q <= 32'(irq_status_q);
                cdsws_pkg::ADDR_IRQ_MASK: rd_data_q <= 32'(irq_mask_q);
                default: rd_data_q <= 32'h0000_0000;
            endcase
        end
        else
        begin
            rd_data_q <= 32'h0000_0000;
        end
    end

    assign rd_data = rd_data_q;
    assign wake_output_one = wake1_q;
    assign wake_output_two = wake2_q;
    assign rf_field_on = rf_q;
    assign gain_gear = gear_q;
    assign card_found_interrupt = irq_q;

    // checking helpers
    logic [31:0] lead_cnt_q;
    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
            lead_cnt_q <= 32'h0000_0000;
        else
            lead_cnt_q <= (state_q == cdsws_pkg::ST_LEAD) ? lead_cnt_q + 32'h0000_0001 : 32'h0000_0000;
    end

    default clocking @(posedge clock); endclocking
    default disable iff (!reset_n);

    sequence single_request;
        state_q == cdsws_pkg::ST_IDLE && start_single && !stop_req;
    endsequence
    sequence lead_ends;
        $past(state_q) == cdsws_pkg::ST_LEAD && state_q == cdsws_pkg::ST_FIELD;
    endsequence

    AST_REF_SOURCE: assert property (state_q == cdsws_pkg::ST_DECIDE && sel == cdsws_pkg::REF_GAIN_CFG
        |-> ref_gain == gain_cfg_q[cdsws_pkg::GAIN_W-1:0])
        else $error("reference source mismatch");
    AST_FIELD_AFTER_WAKE: assert property ($rose(rf_q) && $past(wake1_en)
        |-> wake1_q) else $error("field on without wake output one");
    AST_WAKE2_CAUSE: assert property ($rose(wake2_q) |-> $past(ctl_q[cdsws_pkg::CTL_WAKE2_DETECT])
        && $past(state_q) == cdsws_pkg::ST_DECIDE) else $error("wake two without detect");
    AST_WAKE1_ENTRY: assert property ($rose(wake1_q) |-> state_q == cdsws_pkg::ST_LEAD && !rf_q)
        else $error("wake one outside lead phase");
    AST_LEAD_TIME: assert property (lead_ends |-> lead_cnt_q == 32'(lead_q)
        * 32'(cdsws_pkg::LEAD_UNIT_US) * 32'(cdsws_pkg::US_CYCLES) + 32'(cdsws_pkg::TIMER_LATENCY))
        else $error("lead delay wrong");
    AST_LAG_ORDER: assert property ($fell(wake1_q) && $past(state_q) == cdsws_pkg::ST_LAG
        |-> !rf_q && !$past(rf_q)) else $error("wake one dropped with field on");
    AST_SINGLE_SKIPS_STANDBY: assert property (single_request |=> state_q == cdsws_pkg::ST_LEAD
        || state_q == cdsws_pkg::ST_FIELD) else $error("single shot entered standby");
    AST_DETECT_IRQ: assert property (state_q == cdsws_pkg::ST_DECIDE && hit && !stop_req
        |=> ev_found_q ##1 irq_status_q[0]) else $error("detection not flagged");
    AST_FIELD_STATE: assert property (rf_q == (state_q == cdsws_pkg::ST_FIELD))
        else $error("field not tied to field phase");
    // gear lags the source by one cycle, so only a settled selector and reference are judged
    AST_GEAR_FIELD: assert property ($stable(sel) && $stable(reference_q)
        && sel == cdsws_pkg::REF_STORED
        |-> gear_q == reference_q[cdsws_pkg::GEAR_MSB:cdsws_pkg::GEAR_LSB])
        else $error("gear field wrong");
    AST_LOOP_AGAIN: assert property (state_q == cdsws_pkg::ST_DECIDE && !hit && !single_q && !stop_req
        |=> state_q == cdsws_pkg::ST_STANDBY && tmr_start_q) else $error("loop not repeated");
    AST_STOP_ENDS: assert property (state_q != cdsws_pkg::ST_IDLE && stop_req
        |=> state_q == cdsws_pkg::ST_IDLE && !rf_q ##1 irq_status_q[1]) else $error("stop ignored");
    AST_WAKE1_DISABLED: assert property ($rose(wake1_q) |-> $past(wake1_en))
        else $error("wake one while disabled");
endmodule
`default_nettype wire

// ==== src/cdsws_pkg.sv ====
// shared constants and types of the card-sense supply wake sequencer
`default_nettype none
package cdsws_pkg;
    // timing
    localparam int CLOCK_NS = 5;
    localparam int US_NS = 1000;
    localparam int US_CYCLES = US_NS / CLOCK_NS;
    localparam int LEAD_UNIT_US = 5;
    localparam int LAG_UNIT_US = 5;
    localparam int FIELD_UNIT_US = 8;
    localparam int TIMER_LATENCY = 2;
    localparam int TIMER_W = 16;

    // register addresses
    typedef logic [7:0] cdsws_addr_t;
    localparam cdsws_addr_t ADDR_SINGLE_DETECT = 8'h26;
    localparam cdsws_addr_t ADDR_DETECT_REFERENCE = 8'h34;
    localparam cdsws_addr_t ADDR_FIELD_ON_DURATION = 8'h36;
    localparam cdsws_addr_t ADDR_DETECT_THRESHOLD = 8'h37;
    localparam cdsws_addr_t ADDR_REF_OUT_CONTROL = 8'h38;
    localparam cdsws_addr_t ADDR_OUTPUT_LEAD = 8'h39;
    localparam cdsws_addr_t ADDR_OUTPUT_LAG = 8'h3a;
    localparam cdsws_addr_t ADDR_SENSE_COMMAND = 8'h40;
    localparam cdsws_addr_t ADDR_SENSE_STATUS = 8'h41;
    localparam cdsws_addr_t ADDR_IRQ_STATUS = 8'h42;
    localparam cdsws_addr_t ADDR_IRQ_MASK = 8'h43;
    localparam cdsws_addr_t ADDR_GAIN_CONTROL = 8'h44;

    // field layouts
    localparam int CTL_SEL_MSB = 1;
    localparam int CTL_WAKE1_FIELD = 2;
    localparam int CTL_WAKE2_DETECT = 3;
    localparam int CTL_WAKE1_STANDBY = 4;
    localparam int CTL_W = 5;
    localparam int GAIN_W = 10;
    localparam int GEAR_LSB = 10;
    localparam int GEAR_MSB = 13;
    localparam int REF_W = 14;
    localparam int CMD_START = 0;
    localparam int CMD_STOP = 1;
    localparam int IRQ_FOUND = 0;
    localparam int IRQ_ABORT = 1;
    localparam int IRQ_SINGLE_DONE = 2;
    localparam int IRQ_W = 3;
    localparam int SINGLE_FOUND = 0;
    localparam int SINGLE_DONE = 1;
    localparam int SINGLE_MEAS_LSB = 16;

    // reset values
    localparam logic [7:0] BYTE_RESET = 8'h00;
    localparam logic [REF_W-1:0] REF_RESET = 14'h0000;
    localparam logic [CTL_W-1:0] CTL_RESET = 5'h00;
    localparam logic [IRQ_W-1:0] IRQ_RESET = 3'h0;

    typedef enum logic [1:0] {
        REF_STORED = 2'b00,
        REF_MEASURE = 2'b01,
        REF_GAIN_CFG = 2'b10,
        REF_RESERVED = 2'b11
    } cdsws_refsel_e;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_STANDBY = 3'b001,
        ST_LEAD = 3'b010,
        ST_FIELD = 3'b011,
        ST_LAG = 3'b100,
        ST_DECIDE = 3'b101
    } cdsws_state_e;
endpackage
`default_nettype wire

// ==== src/cdsws_timer_if.sv ====
// request and completion signals between the sequencer and its microsecond timer
`timescale 1ns/1ps
`default_nettype none
interface cdsws_timer_if;
    logic start;
    logic [cdsws_pkg::TIMER_W-1:0] us;
    logic done;
    modport seq (output start, output us, input done);
    modport timer (input start, input us, output done);
endinterface
`default_nettype wire

// ==== src/cdsws_delay_timer.sv ====
// microsecond delay timer with a divided tick enable
`timescale 1ns/1ps
`default_nettype none
module cdsws_delay_timer (
    // clock and reset
    input wire logic clock,
    input wire logic reset_n,
    // request
    cdsws_timer_if.timer tmr
);
    logic [7:0] div_q;
    logic [cdsws_pkg::TIMER_W-1:0] rem_q;
    logic busy_q;
    logic done_q;
    logic tick;

    // tick enable once per microsecond, phase restarted by each request
    assign tick = (div_q == 8'(cdsws_pkg::US_CYCLES - 1));

    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
        begin
            div_q <= 8'h00;
            rem_q <= 16'h0000;
            busy_q <= 1'b0;
            done_q <= 1'b0;
        end
        else if (tmr.start)
        begin
            // a new request cancels any run in progress
            div_q <= 8'h00;
            rem_q <= tmr.us;
            busy_q <= (tmr.us != 16'h0000);
            done_q <= (tmr.us == 16'h0000);
        end
        else if (busy_q)
        begin
            done_q <= 1'b0;
            if (tick)
            begin
                div_q <= 8'h00;
                rem_q <= rem_q - 16'h0001;
                if (rem_q == 16'h0001)
                begin
                    busy_q <= 1'b0;
                    done_q <= 1'b1;
                end
            end
            else
            begin
                div_q <= div_q + 8'h01;
            end
        end
        else
        begin
            done_q <= 1'b0;
        end
    end

    assign tmr.done = done_q;
endmodule
`default_nettype wire

// ==== testbench/cdsws_regulator_model.sv ====
// regulator model: counts the cycles that wake one leads the rf field
`timescale 1ns/1ps
`default_nettype none
module cdsws_regulator_model (
    // clock and reset
    input wire logic clock,
    input wire logic reset_n,
    // wake and field pins, lead count
    input wire logic wake_output_one,
    input wire logic rf_field_on,
    output logic [15:0] lead_q
);
    // counts lag cycles too, so the bench reads it as the field comes on
    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
            lead_q <= 16'h0000;
        else if (wake_output_one && !rf_field_on)
            lead_q <= lead_q + 16'h0001;
    end
endmodule
`default_nettype wire

// ==== testbench/cdsws_sequencer_bench.sv ====
// bench for the card-sense supply wake sequencer
`timescale 1ns/1ps
`default_nettype none
module cdsws_sequencer_bench;
    logic clock = 0, reset_n = 0, wr_en = 0, rd_en = 0, host_select_n = 1, rf_level_detect = 0;
    logic [7:0] addr = 8'h00;
    logic [31:0] wr_data = 32'h0, rd_data;
    logic [9:0] gain_value = 10'h000;
    logic wake_output_one, wake_output_two, rf_field_on, card_found_interrupt;
    logic [3:0] gain_gear;
    logic [15:0] lead_q;
    int n_mismatch = 0, cmp_count = 0, n;
    always #2.5 clock = ~clock;
    cdsws_sequencer #(.STANDBY_US(16'd1)) cdsws_sequencer_inst (.clock(clock),
        .reset_n(reset_n), .addr(addr), .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en),
        .rd_data(rd_data), .gain_value(gain_value), .host_select_n(host_select_n),
        .rf_level_detect(rf_level_detect), .wake_output_one(wake_output_one),
        .wake_output_two(wake_output_two), .rf_field_on(rf_field_on), .gain_gear(gain_gear),
        .card_found_interrupt(card_found_interrupt));
    cdsws_regulator_model cdsws_regulator_model_inst (.clock(clock), .reset_n(reset_n),
        .wake_output_one(wake_output_one), .rf_field_on(rf_field_on), .lead_q(lead_q));
    task automatic give_verdict();
        $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic chk(string s, logic [31:0] e, logic [31:0] g);
        cmp_count++;
        if (g !== e)
        begin
            n_mismatch++;
            $display("[ERR] %s expected %h seen %h", s, e, g);
        end
    endtask
    task automatic wr(logic [7:0] a, logic [31:0] d);
        @(posedge clock);
        addr <= a;
        wr_data <= d;
        wr_en <= 1;
        @(posedge clock);
        wr_en <= 0;
    endtask
    task automatic rd(logic [7:0] a, logic [31:0] e);
        @(posedge clock);
        addr <= a;
        rd_en <= 1;
        @(posedge clock);
        rd_en <= 0;
        #1 chk("rd_data", e, rd_data);
    endtask
    // counts edges until the field reaches level v; a hang ends the run
    task automatic wt(logic v);
        n = 0;
        while (rf_field_on !== v)
        begin
            @(posedge clock);
            #1 n++;
            if (n > 9000)
            begin
                n_mismatch++;
                give_verdict();
            end
        end
    endtask
    task automatic t_regs();
        rd(8'h39, 32'h0);
        wr(8'h39, 32'ha5);
        rd(8'h39, 32'ha5);
        wr(8'h34, 32'h3fff);
        rd(8'h34, 32'h3fff);
        rd(8'h50, 32'h0);
        $display("regs done");
    endtask
    task automatic t_hit();
        wr(8'h34, 32'h03ff);
        wr(8'h37, 32'h0);
        wr(8'h36, 32'h0);
        wr(8'h39, 32'h1);
        wr(8'h3a, 32'h0);
        wr(8'h43, 32'h1);
        wr(8'h38, 32'h1c);
        wr(8'h26, 32'h1);
        wt(1);
        chk("no standby", 1, n < 1100);
        chk("lead", 1002, lead_q);
        chk("wake two early", 0, wake_output_two);
        wt(0);
        repeat (12) @(posedge clock);
        #1 chk("wake one", 0, wake_output_one);
        chk("wake two", 1, wake_output_two);
        chk("irq", 1, card_found_interrupt);
        rd(8'h42, 32'h5);
        @(posedge clock);
        #1 chk("irq", 0, card_found_interrupt);
        $display("hit done");
    endtask
    task automatic t_miss();
        wr(8'h44, 32'h3c00);
        wr(8'h38, 32'h02);
        wr(8'h37, 32'hff);
        wr(8'h36, 32'h1);
        wr(8'h26, 32'h1);
        wt(1);
        chk("gear", 4'hf, gain_gear);
        chk("wake one", 0, wake_output_one);
        wt(0);
        // the count starts two edges after the field went on
        chk("field time", 1602, n + 1);
        repeat (6) @(posedge clock);
        rd(8'h42, 32'h4);
        $display("miss done");
    endtask
    task automatic t_loop();
        // zero reference with zero gain keeps every pass below the threshold
        wr(8'h34, 32'h0);
        wr(8'h38, 32'h0);
        wr(8'h36, 32'h0);
        wr(8'h40, 32'h1);
        wt(1);
        wt(0);
        wt(1);
        @(posedge clock);
        host_select_n <= 0;
        repeat (8) @(posedge clock);
        #1 chk("rf stop", 0, rf_field_on);
        rd(8'h41, 32'h0);
        rd(8'h42, 32'h2);
        @(posedge clock);
        host_select_n <= 1;
        $display("loop done");
    endtask
    // selector 11 never detects; selector 01 takes its reference on the first pass
    task automatic t_meas();
        wr(8'h38, 32'h03);
        gain_value <= 10'h100;
        wr(8'h37, 32'h10);
        wr(8'h26, 32'h0);
        repeat (6) @(posedge clock);
        rd(8'h26, 32'h0100_0002);
        wr(8'h38, 32'h01);
        wr(8'h40, 32'h1);
        wt(1);
        wt(0);
        @(posedge clock);
        gain_value <= 10'h120;
        wt(1);
        wt(0);
        repeat (4) @(posedge clock);
        #1 chk("irq", 1, card_found_interrupt);
        rd(8'h42, 32'h5);
        wr(8'h40, 32'h1);
        rf_level_detect <= 1;
        repeat (8) @(posedge clock);
        rd(8'h41, 32'h0);
        rd(8'h42, 32'h2);
        @(posedge clock);
        rf_level_detect <= 0;
        $display("meas done");
    endtask
    initial
    begin
        repeat (4) @(posedge clock);
        reset_n <= 1;
        repeat (4) @(posedge clock);
        t_regs();
        t_hit();
        t_miss();
        t_loop();
        t_meas();
        give_verdict();
    end
endmodule
`default_nettype wire
